// ---- design/tbac_pkg.sv ----
`default_nettype none
package tbac_pkg;
  localparam int ADDR_W = 6;
  localparam int WORD_W = 16;
  // Bus frame kinds
  localparam logic [2:0] FT_LINK = 3'h0;
  localparam logic [2:0] FT_TOKEN = 3'h1;
  localparam logic [2:0] FT_DATA = 3'h2;
  localparam logic [2:0] FT_EVENT = 3'h3;
  localparam logic [2:0] FT_POLL = 3'h4;
  localparam logic [2:0] FT_ACK = 3'h5;
  localparam logic [2:0] FT_PARAM = 3'h6;
  localparam logic [2:0] FT_MEMB = 3'h7;
  // Network parameter defaults and ranges
  localparam logic [7:0] CYC_AUTO = 8'h00;
  localparam logic [7:0] CYC_MIN = 8'h05;
  localparam logic [5:0] MAX_NODE_DEF = 6'h3e;
  localparam logic [5:0] MAX_NODE_MIN = 6'h02;
  localparam logic [5:0] POLLS_DEF = 6'h04;
  localparam logic [5:0] POLLS_MIN = 6'h01;
  localparam logic [7:0] FRAMES_DEF = 8'h0a;
  localparam logic [7:0] FRAMES_MIN = 8'h05;
  localparam logic [6:0] NET_LOCAL = 7'h00;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_UNIT_US = 1000;
  localparam int CYC_UNIT_CLKS = CYC_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int TOKEN_LOSS_US = 2000;
  localparam int TOKEN_LOSS_CLKS = TOKEN_LOSS_US * (CLK_HZ / 1_000_000);
  localparam int POLL_WAIT_US = 20;
  localparam int POLL_WAIT_CLKS = POLL_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int AVS_WAIT = 2;
  // Host register byte offsets
  localparam logic [8:0] R_CTRL = 9'h000;
  localparam logic [8:0] R_PARAM0 = 9'h004;
  localparam logic [8:0] R_PARAM1 = 9'h008;
  localparam logic [8:0] R_NET = 9'h00c;
  localparam logic [8:0] R_TXWORD = 9'h010;
  localparam logic [8:0] R_EVENT = 9'h014;
  localparam logic [8:0] R_STATUS = 9'h018;
  localparam logic [8:0] R_MEMB_LO = 9'h01c;
  localparam logic [8:0] R_MEMB_HI = 9'h020;
  localparam logic [8:0] R_RXBASE = 9'h100;
endpackage
`default_nettype wire

// ---- design/tbac_if.sv ----
`default_nettype none
interface tbac_if;
  logic param_wr;
  logic [7:0] p_cyc;
  logic [5:0] p_max_node;
  logic [5:0] p_polls;
  logic [7:0] p_frames;
  logic [6:0] net_addr;
  logic link_cmd;
  logic [15:0] tx_word;
  logic evt_req;
  logic [6:0] evt_net;
  logic [15:0] evt_data;
  logic evt_done;
  logic evt_err;
  logic [5:0] dl_rd_addr;
  logic [15:0] dl_rd_data;
  logic link_active;
  logic [5:0] poller_addr;
  logic [63:0] memb;
  modport node (input param_wr, p_cyc, p_max_node, p_polls, p_frames, net_addr, link_cmd, tx_word,
    evt_req, evt_net, evt_data, dl_rd_addr,
    output evt_done, evt_err, dl_rd_data, link_active, poller_addr, memb);
  modport host (output param_wr, p_cyc, p_max_node, p_polls, p_frames, net_addr, link_cmd, tx_word,
    evt_req, evt_net, evt_data, dl_rd_addr,
    input evt_done, evt_err, dl_rd_data, link_active, poller_addr, memb);
endinterface
`default_nettype wire

// ---- design/tbac_node.sv ----
`default_nettype none
module tbac_node #(
  parameter int CYC_UNIT_CLKS = tbac_pkg::CYC_UNIT_CLKS,
  parameter int TOKEN_LOSS_CLKS = tbac_pkg::TOKEN_LOSS_CLKS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [5:0] node_addr,
  tbac_if.node hif,
  input wire logic rx_valid,
  input wire logic [2:0] rx_type,
  input wire logic [5:0] rx_src,
  input wire logic [5:0] rx_dst,
  input wire logic [15:0] rx_data,
  output logic tx_valid,
  output logic [2:0] tx_type,
  output logic [5:0] tx_src,
  output logic [5:0] tx_dst,
  output logic [15:0] tx_data
);
  typedef enum logic [5:0] {
    S_LISTEN = 6'h01, S_HOLD = 6'h02, S_POLL = 6'h04, S_PWAIT = 6'h08, S_BCAST = 6'h10, S_CWAIT = 6'h20
  } tbac_state_t;

  function automatic logic [5:0] next_above(input logic [63:0] m, input logic [5:0] a, input logic [5:0] lim);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 62; i >= 1; i--) begin
      if (6'(i) > a && 6'(i) <= lim && m[i]) begin
        r = 6'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////
  tbac_state_t state_reg;
  logic [63:0] memb_reg;
  logic [5:0] poller_reg;
  logic [7:0] own_cyc_reg, rem_cyc_reg, link_cyc_reg;
  logic [5:0] own_max_reg, rem_max_reg;
  logic [5:0] own_polls_reg, rem_polls_reg;
  logic [7:0] own_frames_reg, rem_frames_reg;
  logic link_on_reg, data_sent_reg;
  logic [7:0] evt_cnt_reg;
  logic [5:0] poll_ptr_reg, poll_cur_reg, poll_cnt_reg;
  logic [2:0] widx_reg;
  logic [31:0] tl_cnt_reg, cyc_cnt_reg, pw_cnt_reg;
  logic [15:0] dl_mem [64];

  logic is_poller;
  logic [7:0] a_cyc, a_frames, evt_allow;
  logic [5:0] a_max, a_polls, nxt, lowest;
  logic tok_in, evt_local;
  logic [31:0] cyc_len;
  assign is_poller = (poller_reg == node_addr);
  // Only the polling node's parameter set governs
  assign a_cyc = is_poller ? own_cyc_reg : rem_cyc_reg;
  assign a_max = is_poller ? own_max_reg : rem_max_reg;
  assign a_polls = is_poller ? own_polls_reg : rem_polls_reg;
  assign a_frames = is_poller ? own_frames_reg : rem_frames_reg;
  // Ten frames give four events, each three more add one
  assign evt_allow = 8'((10'(a_frames) + 10'd2) / 10'd3);
  assign nxt = next_above(memb_reg, node_addr, a_max);
  assign lowest = next_above(memb_reg, 6'h00, a_max);
  assign tok_in = rx_valid && rx_type == tbac_pkg::FT_TOKEN && rx_dst == node_addr;
  assign evt_local = hif.evt_net == tbac_pkg::NET_LOCAL || hif.evt_net == hif.net_addr;
  // Timer length comes from the startup node's link parameters
  assign cyc_len = 32'(link_cyc_reg) * 32'(CYC_UNIT_CLKS);

  ////////////////////////////////////////////////////////////////
  // Stored parameters change at once on a host write, no restart
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      own_cyc_reg <= tbac_pkg::CYC_AUTO;
      own_max_reg <= tbac_pkg::MAX_NODE_DEF;
      own_polls_reg <= tbac_pkg::POLLS_DEF;
      own_frames_reg <= tbac_pkg::FRAMES_DEF;
    end else if (ce && hif.param_wr) begin
      own_cyc_reg <= hif.p_cyc;
      own_max_reg <= hif.p_max_node;
      own_polls_reg <= hif.p_polls;
      own_frames_reg <= hif.p_frames;
    end
  end

  // Received link words for the host to collect
  always_ff @(posedge ref_clk) begin
    if (ce && rx_valid && rx_type == tbac_pkg::FT_DATA) begin
      dl_mem[rx_src] <= rx_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hif.dl_rd_data <= 16'h0000;
      hif.link_active <= 1'b0;
      hif.poller_addr <= 6'h00;
      hif.memb <= 64'h0;
    end else if (ce) begin
      hif.dl_rd_data <= dl_mem[hif.dl_rd_addr];
      hif.link_active <= link_on_reg;
      hif.poller_addr <= poller_reg;
      hif.memb <= memb_reg;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Token, polling and broadcast sequencing
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg <= S_LISTEN;
      memb_reg <= 64'h0;
      poller_reg <= 6'h00;
      rem_cyc_reg <= tbac_pkg::CYC_AUTO;
      rem_max_reg <= tbac_pkg::MAX_NODE_DEF;
      rem_polls_reg <= tbac_pkg::POLLS_DEF;
      rem_frames_reg <= tbac_pkg::FRAMES_DEF;
      link_cyc_reg <= tbac_pkg::CYC_AUTO;
      link_on_reg <= 1'b0;
      data_sent_reg <= 1'b0;
      evt_cnt_reg <= 8'h00;
      poll_ptr_reg <= 6'h01;
      poll_cur_reg <= 6'h00;
      poll_cnt_reg <= 6'h00;
      widx_reg <= 3'h0;
      tl_cnt_reg <= 32'h0;
      cyc_cnt_reg <= 32'h0;
      pw_cnt_reg <= 32'h0;
      tx_valid <= 1'b0;
      tx_type <= tbac_pkg::FT_LINK;
      tx_src <= 6'h00;
      tx_dst <= 6'h00;
      tx_data <= 16'h0000;
      hif.evt_done <= 1'b0;
      hif.evt_err <= 1'b0;
    end else if (ce) begin
      tx_valid <= 1'b0;
      tx_src <= node_addr;
      hif.evt_done <= 1'b0;
      memb_reg[node_addr] <= 1'b1;
      cyc_cnt_reg <= cyc_cnt_reg + 32'd1;
      // Silence counts only while waiting for the token, so a long poll phase is not taken for a loss
      tl_cnt_reg <= (rx_valid || state_reg != S_LISTEN) ? 32'h0 : tl_cnt_reg + 32'd1;
      if (rx_valid) begin
        case (rx_type)
          tbac_pkg::FT_EVENT: evt_cnt_reg <= evt_cnt_reg + 8'd1;
          tbac_pkg::FT_LINK: begin
            link_on_reg <= rx_data[8];
            link_cyc_reg <= rx_data[7:0];
          end
          tbac_pkg::FT_PARAM: begin
            if (rx_dst[0]) begin
              rem_frames_reg <= rx_data[15:8];
              rem_polls_reg <= rx_data[5:0];
            end else begin
              rem_cyc_reg <= rx_data[15:8];
              rem_max_reg <= rx_data[5:0];
            end
          end
          tbac_pkg::FT_MEMB: begin
            memb_reg[rx_dst[1:0] * 16 +: 16] <= rx_data;
            poller_reg <= rx_src;
            evt_cnt_reg <= 8'h00;
          end
          tbac_pkg::FT_POLL: begin
            // Nodes above the maximum address stay silent
            if (rx_dst == node_addr && node_addr <= a_max) begin
              tx_valid <= 1'b1;
              tx_type <= tbac_pkg::FT_ACK;
              tx_dst <= rx_src;
            end
          end
          default: ;
        endcase
      end
      case (state_reg)
        S_LISTEN: begin
          if (tok_in) begin
            data_sent_reg <= 1'b0;
            // Returned token from above closes the token cycle
            if (is_poller && rx_src > node_addr) begin
              poll_cnt_reg <= 6'h00;
              state_reg <= S_POLL;
            end else begin
              cyc_cnt_reg <= 32'h0;
              state_reg <= S_HOLD;
            end
          end else if (tl_cnt_reg >= 32'(TOKEN_LOSS_CLKS)) begin
            // Silent poller dropped; next higher participant takes over
            tl_cnt_reg <= 32'h0;
            if (!is_poller) begin
              memb_reg[poller_reg] <= 1'b0;
              poller_reg <= next_above(memb_reg, poller_reg, a_max);
              if (next_above(memb_reg, poller_reg, a_max) == node_addr) begin
                cyc_cnt_reg <= 32'h0;
                data_sent_reg <= 1'b0;
                state_reg <= S_HOLD;
              end
            end else begin
              poll_cnt_reg <= 6'h00;
              state_reg <= S_POLL;
            end
          end
        end
        S_HOLD: begin
          // Link, data and event frames below are sent only from this state; tokens also go out from S_CWAIT
          tx_valid <= 1'b1;
          if (hif.link_cmd != link_on_reg) begin
            tx_type <= tbac_pkg::FT_LINK;
            tx_dst <= 6'h00;
            tx_data <= {7'h00, hif.link_cmd, own_cyc_reg};
            link_on_reg <= hif.link_cmd;
            link_cyc_reg <= own_cyc_reg;
          end else if (link_on_reg && !data_sent_reg) begin
            tx_type <= tbac_pkg::FT_DATA;
            tx_dst <= 6'h00;
            tx_data <= hif.tx_word;
            data_sent_reg <= 1'b1;
          end else if (hif.evt_req && !hif.evt_done && (evt_cnt_reg < evt_allow || !link_on_reg)) begin
            hif.evt_done <= 1'b1;
            hif.evt_err <= !evt_local;
            tx_valid <= evt_local;
            tx_type <= tbac_pkg::FT_EVENT;
            tx_dst <= 6'h00;
            tx_data <= hif.evt_data;
            evt_cnt_reg <= evt_cnt_reg + 8'(evt_local);
          end else if (nxt != 6'h00) begin
            tx_type <= tbac_pkg::FT_TOKEN;
            tx_dst <= nxt;
            state_reg <= S_LISTEN;
          end else if (is_poller) begin
            tx_valid <= 1'b0;
            poll_cnt_reg <= 6'h00;
            state_reg <= S_POLL;
          end else begin
            tx_type <= tbac_pkg::FT_TOKEN;
            tx_dst <= lowest;
            state_reg <= S_LISTEN;
          end
        end
        S_POLL: begin
          if (poll_cnt_reg >= a_polls) begin
            widx_reg <= 3'h0;
            state_reg <= S_BCAST;
          end else begin
            poll_ptr_reg <= (poll_ptr_reg >= a_max) ? 6'h01 : poll_ptr_reg + 6'd1;
            // Skipping our own address uses up no poll; a degenerate range still ends the phase
            if (poll_ptr_reg != node_addr && poll_ptr_reg <= a_max) begin
              poll_cnt_reg <= poll_cnt_reg + 6'd1;
              tx_valid <= 1'b1;
              tx_type <= tbac_pkg::FT_POLL;
              tx_dst <= poll_ptr_reg;
              poll_cur_reg <= poll_ptr_reg;
              pw_cnt_reg <= 32'h0;
              state_reg <= S_PWAIT;
            end else if (a_max < tbac_pkg::MAX_NODE_MIN) begin
              poll_cnt_reg <= poll_cnt_reg + 6'd1;
            end
          end
        end
        S_PWAIT: begin
          pw_cnt_reg <= pw_cnt_reg + 32'd1;
          if (rx_valid && rx_type == tbac_pkg::FT_ACK && rx_src == poll_cur_reg) begin
            memb_reg[poll_cur_reg] <= 1'b1;
            state_reg <= S_POLL;
          end else if (pw_cnt_reg >= 32'(tbac_pkg::POLL_WAIT_CLKS)) begin
            memb_reg[poll_cur_reg] <= 1'b0;
            state_reg <= S_POLL;
          end
        end
        S_BCAST: begin
          // Four membership words, then two parameter words
          tx_valid <= 1'b1;
          widx_reg <= widx_reg + 3'd1;
          if (widx_reg < 3'h4) begin
            tx_type <= tbac_pkg::FT_MEMB;
            tx_dst <= {4'h0, widx_reg[1:0]};
            tx_data <= memb_reg[widx_reg[1:0] * 16 +: 16];
          end else begin
            tx_type <= tbac_pkg::FT_PARAM;
            tx_dst <= {5'h00, widx_reg[0]};
            tx_data <= widx_reg[0] ? {own_frames_reg, 2'b00, own_polls_reg} : {own_cyc_reg, 2'b00, own_max_reg};
            if (widx_reg[0]) begin
              evt_cnt_reg <= 8'h00;
              state_reg <= S_CWAIT;
            end
          end
        end
        S_CWAIT: begin
          tx_valid <= 1'b0;
          if (lowest != node_addr && lowest != 6'h00) begin
            // A lower node has joined: hand it the polling role
            poller_reg <= lowest;
            tx_valid <= 1'b1;
            tx_type <= tbac_pkg::FT_TOKEN;
            tx_dst <= lowest;
            state_reg <= S_LISTEN;
          end else if (!link_on_reg || link_cyc_reg < tbac_pkg::CYC_MIN || cyc_cnt_reg >= cyc_len) begin
            // Fixed cycle held only while linking with a set time
            cyc_cnt_reg <= 32'h0;
            data_sent_reg <= 1'b0;
            state_reg <= S_HOLD;
          end
        end
        default: state_reg <= S_LISTEN;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- design/tbac_host.sv ----
`default_nettype none
module tbac_host (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  tbac_if.host hif
);
  logic [1:0] wcnt_reg;
  logic req;
  logic [31:0] rd_next;
  assign req = avs_read || avs_write;

  ////////////////////////////////////////////////////////////////
  always_comb begin
    rd_next = 32'h0;
    if (avs_address >= tbac_pkg::R_RXBASE) begin
      rd_next = {16'h0000, hif.dl_rd_data};
    end else begin
      case (avs_address)
        tbac_pkg::R_CTRL: rd_next = {31'h0, hif.link_cmd};
        tbac_pkg::R_PARAM0: rd_next = {16'h0, hif.p_cyc, 2'b00, hif.p_max_node};
        tbac_pkg::R_PARAM1: rd_next = {16'h0, hif.p_frames, 2'b00, hif.p_polls};
        tbac_pkg::R_NET: rd_next = {25'h0, hif.net_addr};
        tbac_pkg::R_TXWORD: rd_next = {16'h0, hif.tx_word};
        tbac_pkg::R_EVENT: rd_next = {30'h0, hif.evt_err, hif.evt_req};
        tbac_pkg::R_STATUS: rd_next = {18'h0, hif.poller_addr, 7'h00, hif.link_active};
        tbac_pkg::R_MEMB_LO: rd_next = hif.memb[31:0];
        tbac_pkg::R_MEMB_HI: rd_next = hif.memb[63:32];
        default: rd_next = 32'h0;
      endcase
    end
  end

  // Every access waits a fixed spell so link words can be fetched
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wcnt_reg <= 2'h0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      hif.dl_rd_addr <= 6'h00;
    end else if (ce) begin
      if (req && avs_waitrequest) begin
        if (wcnt_reg == 2'h0) begin
          hif.dl_rd_addr <= avs_address[7:2];
        end
        if (wcnt_reg == 2'(tbac_pkg::AVS_WAIT)) begin
          avs_readdata <= avs_read ? rd_next : 32'h0;
          avs_waitrequest <= 1'b0;
        end else begin
          wcnt_reg <= wcnt_reg + 2'd1;
        end
      end else begin
        wcnt_reg <= 2'h0;
        avs_waitrequest <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Writes land at the edge the master sees waitrequest low
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hif.param_wr <= 1'b0;
      hif.p_cyc <= tbac_pkg::CYC_AUTO;
      hif.p_max_node <= tbac_pkg::MAX_NODE_DEF;
      hif.p_polls <= tbac_pkg::POLLS_DEF;
      hif.p_frames <= tbac_pkg::FRAMES_DEF;
      hif.net_addr <= tbac_pkg::NET_LOCAL;
      hif.link_cmd <= 1'b0;
      hif.tx_word <= 16'h0000;
      hif.evt_req <= 1'b0;
      hif.evt_net <= tbac_pkg::NET_LOCAL;
      hif.evt_data <= 16'h0000;
    end else if (ce) begin
      hif.param_wr <= 1'b0;
      if (hif.evt_done) begin
        hif.evt_req <= 1'b0;
      end
      if (avs_write && !avs_waitrequest) begin
        case (avs_address)
          tbac_pkg::R_CTRL: hif.link_cmd <= avs_writedata[0];
          tbac_pkg::R_PARAM0: begin
            // Parameter writes dropped while links run
            if (!hif.link_active) begin
              hif.p_cyc <= avs_writedata[15:8];
              hif.p_max_node <= avs_writedata[5:0];
              hif.param_wr <= 1'b1;
            end
          end
          tbac_pkg::R_PARAM1: begin
            if (!hif.link_active) begin
              hif.p_frames <= avs_writedata[15:8];
              hif.p_polls <= avs_writedata[5:0];
              hif.param_wr <= 1'b1;
            end
          end
          tbac_pkg::R_NET: hif.net_addr <= avs_writedata[6:0];
          tbac_pkg::R_TXWORD: hif.tx_word <= avs_writedata[15:0];
          tbac_pkg::R_EVENT: begin
            if (!hif.evt_req) begin
              hif.evt_data <= avs_writedata[15:0];
              hif.evt_net <= avs_writedata[22:16];
              hif.evt_req <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/tbac_properties.sv ----
`default_nettype none
module tbac_properties (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [5:0] node_addr,
  input wire logic rx_valid,
  input wire logic [2:0] rx_type,
  input wire logic [5:0] rx_src,
  input wire logic [5:0] rx_dst,
  input wire logic [5:0] p_max_node,
  input wire logic [6:0] net_addr,
  input wire logic link_cmd,
  input wire logic evt_req,
  input wire logic [6:0] evt_net,
  input wire logic evt_done,
  input wire logic evt_err,
  input wire logic tx_valid,
  input wire logic [2:0] tx_type,
  input wire logic [5:0] tx_src,
  input wire logic [5:0] tx_dst
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  sequence s_frame(logic [2:0] t, logic [5:0] d);
    tx_valid && tx_type == t && tx_dst == d;
  endsequence
  a_quiet_after_reset: assert property ($past(srst) |-> !tx_valid)
    else $error("frame sent right after reset");
  a_src_is_own: assert property (tx_valid |-> tx_src == node_addr)
    else $error("frame sent with a foreign source");
  a_poll_in_range: assert property (
    tx_valid && tx_type == tbac_pkg::FT_POLL |-> tx_dst <= p_max_node && tx_dst != node_addr)
    else $error("poll target out of range");
  a_ack_reply: assert property (
    rx_valid && rx_type == tbac_pkg::FT_POLL && rx_dst == node_addr && node_addr <= p_max_node
    |=> tx_valid && tx_type == tbac_pkg::FT_ACK && tx_dst == $past(rx_src))
    else $error("poll not answered next cycle");
  a_token_fwd: assert property (
    rx_valid && rx_type == tbac_pkg::FT_TOKEN && rx_dst == node_addr && rx_src < node_addr && !evt_req
    && !link_cmd |-> ##2 tx_valid && tx_type == tbac_pkg::FT_TOKEN)
    else $error("idle token not passed on");
  a_memb_burst: assert property (
    s_frame(tbac_pkg::FT_MEMB, 6'h00) |=> s_frame(tbac_pkg::FT_MEMB, 6'h01) ##1 s_frame(tbac_pkg::FT_MEMB, 6'h02)
    ##1 s_frame(tbac_pkg::FT_MEMB, 6'h03) ##1 s_frame(tbac_pkg::FT_PARAM, 6'h00) ##1 s_frame(tbac_pkg::FT_PARAM, 6'h01))
    else $error("membership and parameter broadcast broken");
  a_done_pulse: assert property (evt_done |=> !evt_done)
    else $error("event done longer than one cycle");
  a_evt_net_err: assert property (
    evt_done && evt_net != tbac_pkg::NET_LOCAL && evt_net != net_addr |-> evt_err)
    else $error("foreign network event not refused");
  c_ack: cover property (tx_valid && tx_type == tbac_pkg::FT_ACK);
  c_token: cover property (tx_valid && tx_type == tbac_pkg::FT_TOKEN);
  c_evt_err: cover property (evt_done && evt_err);
endmodule
`default_nettype wire

// ---- sim/test_token_bus_access_control.sv ----
`default_nettype none
module test_token_bus_access_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] own_addr = 6'h03;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic [8:0] avs_address = 9'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_valid = 1'b0;
  logic [2:0] rx_type = 3'h0;
  logic [5:0] rx_src = 6'h00;
  logic [5:0] rx_dst = 6'h00;
  logic [15:0] rx_data = 16'h0000;
  logic tx_valid;
  logic [2:0] tx_type;
  logic [5:0] tx_src;
  logic [5:0] tx_dst;
  logic [15:0] tx_data;
  int n_errors = 0;
  int total_checks = 0;
  ////////////////////////////////////////
  tbac_if i_tbac_if ();
  // Short counts keep the run brief; token loss stays above the poll reply window
  tbac_node #(.CYC_UNIT_CLKS(20), .TOKEN_LOSS_CLKS(300)) i_tbac_node (.ref_clk(ref_clk), .srst(srst), .ce(1'b1),
    .node_addr(own_addr), .hif(i_tbac_if), .rx_valid(rx_valid), .rx_type(rx_type), .rx_src(rx_src),
    .rx_dst(rx_dst), .rx_data(rx_data), .tx_valid(tx_valid), .tx_type(tx_type), .tx_src(tx_src),
    .tx_dst(tx_dst), .tx_data(tx_data));
  // The only unit on this host, so its unit number is unique
  tbac_host i_tbac_host (.ref_clk(ref_clk), .srst(srst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hif(i_tbac_if));
  tbac_properties i_tbac_properties (.ref_clk(ref_clk), .srst(srst), .node_addr(own_addr), .rx_valid(rx_valid),
    .rx_type(rx_type), .rx_src(rx_src), .rx_dst(rx_dst), .p_max_node(i_tbac_if.p_max_node),
    .net_addr(i_tbac_if.net_addr), .link_cmd(i_tbac_if.link_cmd), .evt_req(i_tbac_if.evt_req),
    .evt_net(i_tbac_if.evt_net), .evt_done(i_tbac_if.evt_done), .evt_err(i_tbac_if.evt_err),
    .tx_valid(tx_valid), .tx_type(tx_type), .tx_src(tx_src), .tx_dst(tx_dst));
  initial forever #50 ref_clk = ~ref_clk;
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic av(input logic wr, input logic [8:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    if (n >= 40) chk("waitrequest", 32'h0, 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input string what, input logic [8:0] a, input logic [31:0] exp);
    logic [31:0] q;
    av(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask
  // Keeps rx_valid up when more follows, so bursts land on consecutive cycles
  task automatic send(input logic [2:0] t, input logic [5:0] s, input logic [5:0] d, input logic [15:0] v,
    input logic more);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_type <= t;
    rx_src <= s;
    rx_dst <= d;
    rx_data <= v;
    if (!more) begin
      @(posedge ref_clk);
      rx_valid <= 1'b0;
    end
  endtask
  task automatic wait_tx(input logic [2:0] t, output logic [5:0] d);
    int n;
    n = 0;
    d = 6'h3f;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!(tx_valid === 1'b1 && tx_type === t) && n < 2000);
    if (n < 2000) d = tx_dst;
  endtask
  // Plays node 5 on the bus: answers its polls and hands its token back
  task automatic run_cycle(output int polls);
    int n;
    polls = 0;
    n = 0;
    while (n < 3000) begin
      @(negedge ref_clk);
      n++;
      if (tx_valid === 1'b1 && tx_type === tbac_pkg::FT_MEMB && tx_dst === 6'h00) break;
      if (tx_valid === 1'b1 && tx_type === tbac_pkg::FT_POLL) begin
        polls++;
        if (tx_dst === 6'h05) send(tbac_pkg::FT_ACK, 6'h05, own_addr, 16'h0000, 1'b0);
      end
      if (tx_valid === 1'b1 && tx_type === tbac_pkg::FT_TOKEN) begin
        chk("token target", 32'h5, {26'h0, tx_dst});
        send(tbac_pkg::FT_TOKEN, 6'h05, own_addr, 16'h0000, 1'b0);
      end
    end
  endtask
  ////////////////////////////////////////
  task automatic takeover_test();
    logic [5:0] d;
    send(tbac_pkg::FT_POLL, 6'h01, own_addr, 16'h0000, 1'b0);
    wait_tx(tbac_pkg::FT_ACK, d);
    chk("ack target", 32'h1, {26'h0, d});
    send(tbac_pkg::FT_MEMB, 6'h01, 6'h00, 16'h000a, 1'b1);
    send(tbac_pkg::FT_MEMB, 6'h01, 6'h01, 16'h0000, 1'b1);
    send(tbac_pkg::FT_MEMB, 6'h01, 6'h02, 16'h0000, 1'b1);
    send(tbac_pkg::FT_MEMB, 6'h01, 6'h03, 16'h0000, 1'b0);
    rd_chk("poller", tbac_pkg::R_STATUS, 32'h0000_0100);
    send(tbac_pkg::FT_TOKEN, 6'h01, own_addr, 16'h0000, 1'b0);
    wait_tx(tbac_pkg::FT_TOKEN, d);
    chk("token wrap", 32'h1, {26'h0, d});
    wait_tx(tbac_pkg::FT_POLL, d);
    rd_chk("takeover", tbac_pkg::R_STATUS, 32'h0000_0300);
    rd_chk("members", tbac_pkg::R_MEMB_LO, 32'h0000_0008);
  endtask
  task automatic param_test();
    logic [31:0] q;
    int n;
    rd_chk("param0", tbac_pkg::R_PARAM0, 32'h0000_003e);
    rd_chk("param1", tbac_pkg::R_PARAM1, 32'h0000_0a04);
    rd_chk("unmapped", 9'h024, 32'h0000_0000);
    av(1'b1, tbac_pkg::R_PARAM0, 32'h0000_0005, q);
    av(1'b1, tbac_pkg::R_PARAM1, 32'h0000_0a02, q);
    rd_chk("param1 new", tbac_pkg::R_PARAM1, 32'h0000_0a02);
    run_cycle(n);
    run_cycle(n);
    chk("polls", 32'h2, n);
    run_cycle(n);
    chk("polls", 32'h2, n);
    rd_chk("members", tbac_pkg::R_MEMB_LO, 32'h0000_0028);
  endtask
  task automatic event_test();
    logic [31:0] q;
    int n;
    n = 0;
    av(1'b1, tbac_pkg::R_NET, 32'h0000_0005, q);
    av(1'b1, tbac_pkg::R_EVENT, 32'h0009_1234, q);
    do begin
      av(1'b0, tbac_pkg::R_EVENT, 32'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 300);
    chk("event result", 32'h0000_0002, q);
  endtask
  task automatic link_test();
    logic [31:0] q;
    logic [5:0] d;
    av(1'b1, tbac_pkg::R_TXWORD, 32'h0000_5a3c, q);
    av(1'b1, tbac_pkg::R_CTRL, 32'h0000_0001, q);
    wait_tx(tbac_pkg::FT_LINK, d);
    chk("link frame", 32'h0000_0100, {16'h0000, tx_data});
    wait_tx(tbac_pkg::FT_DATA, d);
    chk("link word", 32'h0000_5a3c, {16'h0000, tx_data});
    send(tbac_pkg::FT_DATA, 6'h05, 6'h00, 16'h0c3a, 1'b0);
    rd_chk("link active", tbac_pkg::R_STATUS, 32'h0000_0301);
    rd_chk("peer word", 9'h114, 32'h0000_0c3a);
    av(1'b1, tbac_pkg::R_PARAM0, 32'h0000_0004, q);
    rd_chk("param0 kept", tbac_pkg::R_PARAM0, 32'h0000_0005);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #3_000_000;
    n_errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    // The follower case must start before the token-loss timer runs out
    takeover_test();
    param_test();
    event_test();
    link_test();
    give_verdict();
  end
endmodule
`default_nettype wire
